// ---- design/smgr_general_regs.sv ----
// General register bank of one socket manager on a lite register bus
`timescale 1ns/1ps
module smgr_general_regs
#(
    parameter int MGR_SEL_W     = 5,
    parameter int REG_SEL_W     = 8,
    parameter int MANAGER_ID    = 0,
    parameter int TRIG_W        = 4,
    parameter bit BSID_PRESENT  = 1'b0,
    parameter bit LOST_POSSIBLE = 1'b1,
    parameter bit CLEARING_USED = 1'b0
)
(
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    // Register bus write address and data
    input  wire logic [31:0]               s_axi_reg_awaddr,
    input  wire logic                      s_axi_reg_awvalid,
    output logic                           s_axi_reg_awready,
    input  wire logic [31:0]               s_axi_reg_wdata,
    input  wire logic [3:0]                s_axi_reg_wstrb,
    input  wire logic                      s_axi_reg_wvalid,
    output logic                           s_axi_reg_wready,
    // Register bus write response
    output logic [1:0]                     s_axi_reg_bresp,
    output logic                           s_axi_reg_bvalid,
    input  wire logic                      s_axi_reg_bready,
    // Register bus read
    input  wire logic [31:0]               s_axi_reg_araddr,
    input  wire logic                      s_axi_reg_arvalid,
    output logic                           s_axi_reg_arready,
    output logic [31:0]                    s_axi_reg_rdata,
    output logic [1:0]                     s_axi_reg_rresp,
    output logic                           s_axi_reg_rvalid,
    input  wire logic                      s_axi_reg_rready,
    // Manager condition
    input  smgr_pkg::smgr_status_in_type   status_in,
    // Command to the manager
    output logic                           command_valid,
    output smgr_pkg::smgr_cmd_type         command,
    // Software trigger to the manager
    output logic                           software_trigger_pending,
    output logic [TRIG_W-1:0]              software_trigger_id,
    input  wire logic                      software_trigger_taken
);
    import smgr_pkg::*;

    localparam int BANK_LSB = SMGR_ADDR_LSB + REG_SEL_W;
    localparam int MGR_LSB  = BANK_LSB + SMGR_BANK_W;
    localparam logic [REG_SEL_W-1:0] SEL_STATUS  = REG_SEL_W'(SMGR_SEL_STATUS);
    localparam logic [REG_SEL_W-1:0] SEL_TRIGGER =
        REG_SEL_W'(SMGR_SEL_TRIGGER);
    localparam logic [MGR_SEL_W-1:0] MGR_MATCH   = MGR_SEL_W'(MANAGER_ID);

    // Refuse layouts the address or trigger word cannot hold
    if (MGR_LSB + MGR_SEL_W > 32 || MGR_SEL_W < 1 || REG_SEL_W < 1)
        $error("smgr_general_regs: address fields exceed 32 bits");
    if (TRIG_W < 1 || TRIG_W > 30)
        $error("smgr_general_regs: trigger width must be 1 to 30");
    if (MANAGER_ID < 0 || MANAGER_ID >= (1 << MGR_SEL_W))
        $error("smgr_general_regs: manager id does not fit its field");

    logic [31:0]        status_word;
    logic               wr_fire;
    logic               wr_hit;
    logic               wr_full;
    logic [REG_SEL_W-1:0] wr_sel;
    logic               wr_cmd;
    logic               wr_trig;
    logic               ar_fire;
    logic               ar_hit;
    logic [REG_SEL_W-1:0] ar_sel;
    logic               bvalid_r;
    logic               bvalid_nxt;
    logic [1:0]         bresp_r;
    logic [1:0]         bresp_nxt;
    logic               rvalid_r;
    logic               rvalid_nxt;
    logic [1:0]         rresp_r;
    logic [1:0]         rresp_nxt;
    logic [31:0]        rdata_r;
    logic [31:0]        rdata_nxt;
    logic               cmd_valid_r;
    logic               cmd_valid_nxt;
    smgr_cmd_type       cmd_r;
    smgr_cmd_type       cmd_nxt;
    smgr_cmd_type       cmd_in;
    logic               pend_r;
    logic               pend_nxt;
    logic [TRIG_W-1:0]  trig_r;
    logic [TRIG_W-1:0]  trig_nxt;

    // Status word from the live manager condition
    smgr_status_fmt
    #(
        .BSID_PRESENT  (BSID_PRESENT),
        .LOST_POSSIBLE (LOST_POSSIBLE),
        .CLEARING_USED (CLEARING_USED)
    )
    u_status_fmt
    (
        .st_in       (status_in),
        .status_word (status_word)
    );

    // Address decode: manager, bank, select, two zero bits
    always_comb
    begin
        wr_sel = s_axi_reg_awaddr[SMGR_ADDR_LSB +: REG_SEL_W];         // RULE17
        wr_hit = s_axi_reg_awaddr[MGR_LSB +: MGR_SEL_W] == MGR_MATCH &&
                 s_axi_reg_awaddr[BANK_LSB +: SMGR_BANK_W] ==
                 SMGR_BANK_GENERAL;                                    // RULE17
        ar_sel = s_axi_reg_araddr[SMGR_ADDR_LSB +: REG_SEL_W];         // RULE17
        ar_hit = s_axi_reg_araddr[MGR_LSB +: MGR_SEL_W] == MGR_MATCH &&
                 s_axi_reg_araddr[BANK_LSB +: SMGR_BANK_W] ==
                 SMGR_BANK_GENERAL;                                    // RULE17
    end

    // Write channel: address and data taken together, one at a time
    assign wr_fire = s_axi_reg_awvalid & s_axi_reg_wvalid & ~bvalid_r;
    assign s_axi_reg_awready = s_axi_reg_awvalid & s_axi_reg_wvalid &
                               ~bvalid_r;
    assign s_axi_reg_wready  = s_axi_reg_awready;
    // Partial writes are answered but not acted on: commands are whole words
    assign wr_full = s_axi_reg_wstrb == SMGR_STRB_FULL;
    assign wr_cmd  = wr_fire & wr_hit & wr_full & (wr_sel == SEL_STATUS);
    assign wr_trig = wr_fire & wr_hit & wr_full & (wr_sel == SEL_TRIGGER);
    assign cmd_in  = smgr_cmd_type'(s_axi_reg_wdata);

    // Write response next state
    always_comb
    begin
        bvalid_nxt = bvalid_r;
        bresp_nxt  = bresp_r;
        if (wr_fire)
        begin
            bvalid_nxt = 1'b1;
            bresp_nxt  = wr_hit ? SMGR_RESP_OKAY : SMGR_RESP_DECERR;  // RULE20
        end
        else if (s_axi_reg_bready)
            bvalid_nxt = 1'b0;
    end

    // Command issue: a write at select 0 never reaches the read path
    always_comb
    begin
        cmd_valid_nxt = 1'b0;
        cmd_nxt       = cmd_r;
        if (wr_cmd && cmd_in.code <= SMGR_CMD_USER)                   // RULE18
        begin
            cmd_valid_nxt = 1'b1;                                      // RULE3
            cmd_nxt       = cmd_in;                                    // RULE2
        end
    end

    // Trigger: a new write overrides a clear in the same cycle
    always_comb
    begin
        pend_nxt = pend_r;
        trig_nxt = trig_r;
        if (wr_trig)
        begin
            pend_nxt = 1'b1;                                           // RULE4
            trig_nxt = s_axi_reg_wdata[TRIG_W-1:0];                    // RULE19
        end
        else if (software_trigger_taken)
            pend_nxt = 1'b0;
    end

    // Read channel: one outstanding read, data held until accepted
    assign ar_fire = s_axi_reg_arvalid & ~rvalid_r;
    assign s_axi_reg_arready = ~rvalid_r;

    always_comb
    begin
        rvalid_nxt = rvalid_r;
        rresp_nxt  = rresp_r;
        rdata_nxt  = rdata_r;
        if (ar_fire)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = ar_hit ? SMGR_RESP_OKAY : SMGR_RESP_DECERR;
            rdata_nxt  = '0;                                           // RULE20
            if (ar_hit && ar_sel == SEL_STATUS)
                rdata_nxt = status_word;                               // RULE1
            else if (ar_hit && ar_sel == SEL_TRIGGER)
            begin
                rdata_nxt[SMGR_PEND_BIT] = pend_r;                     // RULE19
                rdata_nxt[TRIG_W-1:0]    = trig_r;                     // RULE4
            end
        end
        else if (s_axi_reg_rready)
            rvalid_nxt = 1'b0;
    end

    // All bank state registers
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            bvalid_r    <= 1'b0;
            bresp_r     <= SMGR_RESP_OKAY;
            rvalid_r    <= 1'b0;
            rresp_r     <= SMGR_RESP_OKAY;
            rdata_r     <= '0;
            cmd_valid_r <= 1'b0;
            cmd_r       <= '0;
            pend_r      <= 1'b0;
            trig_r      <= '0;
        end
        else
        begin
            bvalid_r    <= bvalid_nxt;
            bresp_r     <= bresp_nxt;
            rvalid_r    <= rvalid_nxt;
            rresp_r     <= rresp_nxt;
            rdata_r     <= rdata_nxt;
            cmd_valid_r <= cmd_valid_nxt;
            cmd_r       <= cmd_nxt;
            pend_r      <= pend_nxt;
            trig_r      <= trig_nxt;
        end
    end

    // Outputs
    assign s_axi_reg_bvalid         = bvalid_r;
    assign s_axi_reg_bresp          = bresp_r;
    assign s_axi_reg_rvalid         = rvalid_r;
    assign s_axi_reg_rresp          = rresp_r;
    assign s_axi_reg_rdata          = rdata_r;
    assign command_valid            = cmd_valid_r;
    assign command                  = cmd_r;
    assign software_trigger_pending = pend_r;
    assign software_trigger_id      = trig_r;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_STATUS_READ: assert property (                                 // RULE1
        ar_fire && ar_hit && ar_sel == SEL_STATUS |=>
        rvalid_r && rdata_r == $past(status_word))
        else $error("status read returned wrong word");

    AST_CMD_WRITE: assert property (                                   // RULE3
        wr_cmd && cmd_in.code <= SMGR_CMD_USER |=>
        cmd_valid_r && cmd_r == $past(s_axi_reg_wdata) ##1 !cmd_valid_r)
        else $error("command write not issued as one pulse");

    AST_CMD_RESERVED: assert property (                                // RULE18
        wr_cmd && cmd_in.code > SMGR_CMD_USER |=> !cmd_valid_r)
        else $error("reserved command code was issued");

    AST_CMD_NO_READBACK: assert property (                             // RULE2
        wr_cmd ##[1:8] (ar_fire && ar_hit && ar_sel == SEL_STATUS) |=>
        rdata_r == $past(status_word))
        else $error("command word leaked into read data");

    AST_TRIG_SET: assert property (                                    // RULE4
        wr_trig |=> pend_r && trig_r == $past(s_axi_reg_wdata[TRIG_W-1:0]))
        else $error("trigger write not pending");

    AST_TRIG_READ: assert property (                                   // RULE19
        ar_fire && ar_hit && ar_sel == SEL_TRIGGER |=>
        rdata_r[SMGR_PEND_BIT] == $past(pend_r) &&
        rdata_r[SMGR_PEND_BIT-1:TRIG_W] == '0)
        else $error("trigger word read wrong");

    AST_TRIG_CLEAR: assert property (                                  // RULE19
        pend_r && software_trigger_taken && !wr_trig |=> !pend_r)
        else $error("taken trigger stayed pending");

    AST_SHUT_BIT: assert property (                                    // RULE7
        status_word[SMGR_SHUT_BIT] == status_in.shutdown)
        else $error("shutdown bit mismatch");

    AST_SHUT_STATE: assert property (                                  // RULE16
        status_in.shutdown |-> status_word[SMGR_STATE_LSB +: 3] ==
        {2'b00, status_in.module_shutdown_acknowledge})
        else $error("shutdown state does not mirror acknowledge");

    AST_ERR_NONE: assert property (                                    // RULE8
        status_in.errors == '0 |-> status_word[SMGR_ERR_LSB +: 4] ==
        SMGR_ERR_NONE)
        else $error("error field set with no error");

    AST_ERR_DEFINED: assert property (                                 // RULE12
        status_word[SMGR_ERR_LSB +: 4] <= SMGR_ERR_BADFMT ||
        status_word[SMGR_ERR_LSB +: 4] == SMGR_ERR_UNKNOWN)
        else $error("reserved error code reported");

    AST_MODULE_ID: assert property (                                   // RULE6
        status_word[SMGR_MID_LSB +: 16] == status_in.module_identifier)
        else $error("module identifier mismatch");

    AST_UNMAPPED: assert property (                                    // RULE20
        wr_fire && wr_hit && wr_sel != SEL_STATUS && wr_sel != SEL_TRIGGER
        |=> !cmd_valid_r && $stable(trig_r) && bresp_r == SMGR_RESP_OKAY)
        else $error("unmapped write had side effects");

    AST_RDATA_HOLD: assert property (
        rvalid_r && !s_axi_reg_rready |=> rvalid_r && $stable(rdata_r))
        else $error("read data dropped before accepted");

    COV_SHUTDOWN_CMD: cover property (
        wr_cmd && cmd_in.code == SMGR_CMD_SHUTDOWN);
    COV_TRIG_REPLACE: cover property (pend_r && wr_trig);
    COV_READ_IN_SHUTDOWN: cover property (
        ar_fire && ar_hit && ar_sel == SEL_STATUS && status_in.shutdown);
    COV_SET_AND_TAKE: cover property (wr_trig && software_trigger_taken);
endmodule // smgr_general_regs

// ---- include/smgr_pkg.sv ----
// Constants, types and field layout for the socket manager general registers
// What this block does
// RULE1 - Select 0 read returns manager status word
// RULE2 - Select 0 read is status, write is command
// RULE3 - Each command write is acted upon; partial-strobe writes are answered but not issued
// RULE4 - Select 1 is trigger word, read shows pending
// RULE5 - Bits 31:24 bitstream id, else reserved zero
// RULE6 - Bits 23:8 report module identifier
// RULE7 - Bit 7 is one only in shutdown
// RULE8 - Error 0000 none, 0001 zero-byte bitstream
// RULE9 - Error 0010 port, 0100 fetch, 0101 both
// RULE10 - Error 0011 port lost, 0110 with fetch
// RULE11 - Error 1000 bad format, 0111 bad size
// RULE12 - Error 1111 unknown; reserved codes never reported
// RULE13 - Active: 001 hardware, 010 software shutdown step
// RULE14 - Active: 000 empty,100 load,101,110,111 full
// RULE15 - Active: 011 clearing load, only if used
// RULE16 - Shutdown: state mirrors shutdown acknowledge input
// RULE17 - Address is manager, bank, select, then 00
// RULE18 - Command code 0..4 defined, others reserved
// RULE19 - Trigger bit 31 pending; new write replaces
// RULE20 - Undefined selects read zero, writes ignored
package smgr_pkg;
    // Address layout
    localparam int          SMGR_ADDR_LSB     = 2;
    localparam int          SMGR_BANK_W       = 2;
    localparam logic [1:0]  SMGR_BANK_GENERAL = 2'h0;
    localparam int          SMGR_SEL_STATUS   = 0;
    localparam int          SMGR_SEL_TRIGGER  = 1;
    localparam logic [3:0]  SMGR_STRB_FULL    = 4'hF;
    // Bus answers
    localparam logic [1:0]  SMGR_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  SMGR_RESP_DECERR  = 2'h3;
    // Status word field positions
    localparam int          SMGR_BSID_LSB     = 24;
    localparam int          SMGR_MID_LSB      = 8;
    localparam int          SMGR_SHUT_BIT     = 7;
    localparam int          SMGR_ERR_LSB      = 3;
    localparam int          SMGR_STATE_LSB    = 0;
    localparam int          SMGR_PEND_BIT     = 31;
    // Command codes
    localparam logic [7:0]  SMGR_CMD_SHUTDOWN = 8'h00;
    localparam logic [7:0]  SMGR_CMD_RESTART  = 8'h01;
    localparam logic [7:0]  SMGR_CMD_RESTART_S= 8'h02;
    localparam logic [7:0]  SMGR_CMD_PROCEED  = 8'h03;
    localparam logic [7:0]  SMGR_CMD_USER     = 8'h04;
    // Error codes
    localparam logic [3:0]  SMGR_ERR_NONE     = 4'h0;
    localparam logic [3:0]  SMGR_ERR_ZERO     = 4'h1;
    localparam logic [3:0]  SMGR_ERR_PORT     = 4'h2;
    localparam logic [3:0]  SMGR_ERR_LOST     = 4'h3;
    localparam logic [3:0]  SMGR_ERR_FETCH    = 4'h4;
    localparam logic [3:0]  SMGR_ERR_PORT_F   = 4'h5;
    localparam logic [3:0]  SMGR_ERR_LOST_F   = 4'h6;
    localparam logic [3:0]  SMGR_ERR_BADSIZE  = 4'h7;
    localparam logic [3:0]  SMGR_ERR_BADFMT   = 4'h8;
    localparam logic [3:0]  SMGR_ERR_UNKNOWN  = 4'hF;
    // State codes
    localparam logic [2:0]  SMGR_ST_EMPTY     = 3'h0;
    localparam logic [2:0]  SMGR_ST_HW_SHUT   = 3'h1;
    localparam logic [2:0]  SMGR_ST_SW_SHUT   = 3'h2;
    localparam logic [2:0]  SMGR_ST_CLEARING  = 3'h3;
    localparam logic [2:0]  SMGR_ST_LOADING   = 3'h4;
    localparam logic [2:0]  SMGR_ST_SW_START  = 3'h5;
    localparam logic [2:0]  SMGR_ST_RESET     = 3'h6;
    localparam logic [2:0]  SMGR_ST_FULL      = 3'h7;
    localparam logic [2:0]  SMGR_ST_ACK_LOW   = 3'h0;
    localparam logic [2:0]  SMGR_ST_ACK_HIGH  = 3'h1;

    // Active-state steps of the manager
    typedef enum logic [2:0] {
        SMGR_EMPTY,
        SMGR_HW_SHUTDOWN,
        SMGR_SW_SHUTDOWN,
        SMGR_CLEARING,
        SMGR_LOADING,
        SMGR_SW_STARTUP,
        SMGR_MODULE_RESET,
        SMGR_FULL
    } smgr_state_type;

    // Error conditions raised by the fetch and load paths
    typedef struct packed {
        logic unknown;
        logic bad_format;
        logic bad_size;
        logic port_lost;
        logic fetch_error;
        logic load_port_error;
        logic zero_size;
    } smgr_err_type;

    // Manager condition reported through the status word
    typedef struct packed {
        logic [7:0]     bitstream_identifier;
        logic [15:0]    module_identifier;
        logic           shutdown;
        logic           module_shutdown_acknowledge;
        smgr_state_type state;
        smgr_err_type   errors;
    } smgr_status_in_type;

    // Command word as written, layout matches bits 31:0
    typedef struct packed {
        logic [15:0]    halfword_field;
        logic [7:0]     byte_field;
        logic [7:0]     code;
    } smgr_cmd_type;
endpackage

// ---- design/smgr_status_fmt.sv ----
// Status word assembly: error encoding and state field selection
`timescale 1ns/1ps
module smgr_status_fmt
#(
    parameter bit BSID_PRESENT  = 1'b0,
    parameter bit LOST_POSSIBLE = 1'b1,
    parameter bit CLEARING_USED = 1'b0
)
(
    // Manager condition
    input  smgr_pkg::smgr_status_in_type st_in,
    // Assembled word
    output logic [31:0]                  status_word
);
    import smgr_pkg::*;

    logic [3:0] err_code;
    logic [2:0] state_code;
    logic       lost;

    // Error encoding; only defined codes can ever leave here
    always_comb
    begin
        lost = st_in.errors.port_lost & LOST_POSSIBLE;                 // RULE10
        if (st_in.errors.unknown)
            err_code = SMGR_ERR_UNKNOWN;                               // RULE12
        else if (st_in.errors.bad_format)
            err_code = SMGR_ERR_BADFMT;                                // RULE11
        else if (st_in.errors.bad_size)
            err_code = SMGR_ERR_BADSIZE;                               // RULE11
        else if (lost && st_in.errors.load_port_error)
            err_code = SMGR_ERR_UNKNOWN;                               // RULE12
        else if (lost && st_in.errors.fetch_error)
            err_code = SMGR_ERR_LOST_F;                                // RULE10
        else if (st_in.errors.load_port_error && st_in.errors.fetch_error)
            err_code = SMGR_ERR_PORT_F;                                // RULE9
        else if (st_in.errors.fetch_error)
            err_code = SMGR_ERR_FETCH;                                 // RULE9
        else if (lost)
            err_code = SMGR_ERR_LOST;                                  // RULE10
        else if (st_in.errors.load_port_error)
            err_code = SMGR_ERR_PORT;                                  // RULE9
        else if (st_in.errors.zero_size)
            err_code = SMGR_ERR_ZERO;                                  // RULE8
        else
            err_code = SMGR_ERR_NONE;                                  // RULE8
    end

    // State field: mirrors the acknowledge in shutdown, else the step
    always_comb
    begin
        if (st_in.shutdown)
            state_code = st_in.module_shutdown_acknowledge ?
                         SMGR_ST_ACK_HIGH : SMGR_ST_ACK_LOW;           // RULE16
        else
        begin
            case (st_in.state)
                SMGR_EMPTY:        state_code = SMGR_ST_EMPTY;         // RULE14
                SMGR_HW_SHUTDOWN:  state_code = SMGR_ST_HW_SHUT;       // RULE13
                SMGR_SW_SHUTDOWN:  state_code = SMGR_ST_SW_SHUT;       // RULE13
                // Targets without clearing never show 011
                SMGR_CLEARING:     state_code = CLEARING_USED ?
                                   SMGR_ST_CLEARING : SMGR_ST_LOADING; // RULE15
                SMGR_LOADING:      state_code = SMGR_ST_LOADING;       // RULE14
                SMGR_SW_STARTUP:   state_code = SMGR_ST_SW_START;      // RULE14
                SMGR_MODULE_RESET: state_code = SMGR_ST_RESET;         // RULE14
                SMGR_FULL:         state_code = SMGR_ST_FULL;          // RULE14
                default:           state_code = SMGR_ST_EMPTY;
            endcase
        end
    end

    // Field packing
    always_comb
    begin
        status_word = '0;
        if (BSID_PRESENT)
            status_word[SMGR_BSID_LSB +: 8] = st_in.bitstream_identifier; // RULE5
        status_word[SMGR_MID_LSB +: 16] = st_in.module_identifier;      // RULE6
        status_word[SMGR_SHUT_BIT]      = st_in.shutdown;               // RULE7
        status_word[SMGR_ERR_LSB +: 4]  = err_code;
        status_word[SMGR_STATE_LSB +: 3]= state_code;
    end
endmodule // smgr_status_fmt

// ---- verification/tb_smgr_general_regs.sv ----
// Self-checking bench for the socket manager general registers
`timescale 1ns/1ps
module tb_smgr_general_regs;
    import smgr_pkg::*;
    // Bus handshakes and manager side
    logic               clock, rst_n, awv, wv, bre, arv, rre, taken, cv;
    logic               awr, wrd, bv, arr, rv, cmdv, pend;
    logic [31:0]        aw, wd, ar, rdata, e;
    logic [3:0]         ws, tid;
    logic [1:0]         bresp, rresp;
    smgr_status_in_type sti;
    smgr_cmd_type       cmd;
    int                 n_errors = 0;
    int                 check_count = 0;
    // Error inputs and the code each one must produce
    logic [6:0] ev [10] = '{7'h00, 7'h01, 7'h02, 7'h08, 7'h04,
                            7'h06, 7'h0C, 7'h10, 7'h20, 7'h40};
    logic [3:0] ec [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
                            4'h5, 4'h6, 4'h7, 4'h8, 4'hF};

    smgr_general_regs u_dut (.clock(clock), .rst_n(rst_n),
        .s_axi_reg_awaddr(aw), .s_axi_reg_awvalid(awv),
        .s_axi_reg_awready(awr), .s_axi_reg_wdata(wd),
        .s_axi_reg_wstrb(ws), .s_axi_reg_wvalid(wv),
        .s_axi_reg_wready(wrd), .s_axi_reg_bresp(bresp),
        .s_axi_reg_bvalid(bv), .s_axi_reg_bready(bre),
        .s_axi_reg_araddr(ar), .s_axi_reg_arvalid(arv),
        .s_axi_reg_arready(arr), .s_axi_reg_rdata(rdata),
        .s_axi_reg_rresp(rresp), .s_axi_reg_rvalid(rv),
        .s_axi_reg_rready(rre), .status_in(sti), .command_valid(cmdv),
        .command(cmd), .software_trigger_pending(pend),
        .software_trigger_id(tid), .software_trigger_taken(taken));

    // Free-running 10 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // One comparison; an unknown bit matches only an unknown bit in the same place
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Write: hold both channels until accepted, then take the response
    task automatic wr_reg(input logic [31:0] a, d, input logic [1:0] er);
        @(negedge clock);
        {aw, wd, awv, wv} = {a, d, 2'b11};
        do @(posedge clock); while (awr !== 1'b1);
        @(negedge clock);
        {awv, wv, bre} = 3'b001;
        cv = cmdv; // Pulse stands in the cycle after acceptance
        do @(posedge clock); while (bv !== 1'b1);
        chk(bresp, er);
        @(negedge clock) bre = 1'b0;
    endtask

    // Read: status is sampled at the accepting edge
    task automatic rd_reg(input logic [31:0] a, d, input logic [1:0] er);
        @(negedge clock);
        {ar, arv} = {a, 1'b1};
        do @(posedge clock); while (arr !== 1'b1);
        @(negedge clock);
        {arv, rre} = 2'b01;
        do @(posedge clock); while (rv !== 1'b1);
        chk(rdata, d);
        chk(rresp, er);
        @(negedge clock) rre = 1'b0;
    endtask

    // Verdict and end of run
    task final_report;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog: the tests need well under a thousand cycles
    initial
    begin
        #1000000;
        n_errors++;
        final_report;
    end

    // Main sequence
    initial
    begin
        {rst_n, awv, wv, bre, arv, rre, taken, aw, wd, ar} = '0;
        ws = 4'hF;
        sti = '0;
        repeat (12) @(posedge clock);
        @(negedge clock) rst_n = 1'b1;
        // Every error input and every active state through select 0
        for (int i = 0; i < 10; i++)
        begin
            sti = {8'h5A, 16'hA5C3, 2'b00, 3'(i), ev[i]};
            e = {8'h00, 16'hA5C3, 1'b0, ec[i], (i % 8 == 3) ? 3'h4 : 3'(i)};
            rd_reg(0, e, 0);
        end
        // Shutdown: the state field follows the acknowledge input
        sti = {8'h5A, 16'h0011, 2'b11, SMGR_LOADING, 7'h00};
        rd_reg(0, 32'h0000_1181, 0);
        sti.module_shutdown_acknowledge = 1'b0;
        rd_reg(0, 32'h0000_1180, 0);
        $display("test status done");
        // Every command code plus one reserved code
        for (int c = 0; c < 6; c++)
        begin
            wr_reg(0, {16'hBEEF, 8'h5C, 8'(c)}, 0);
            chk(cv, c < 5);
            if (c < 5)
                chk(cmd, {16'hBEEF, 8'h5C, 8'(c)});
        end
        // The command just written must not show in the status read
        rd_reg(0, 32'h0000_1180, 0);
        $display("test command done");
        // Trigger: pending flag, replacement, consumption, partial strobe
        wr_reg(4, 32'h9, 0);
        rd_reg(4, 32'h8000_0009, 0);
        chk({pend, tid}, 5'h19);
        wr_reg(4, 32'hFFFF_FFF3, 0);
        rd_reg(4, 32'h8000_0003, 0);
        @(negedge clock) taken = 1'b1;
        @(negedge clock) taken = 1'b0;
        rd_reg(4, 32'h3, 0);
        chk({pend, tid}, 5'h03);
        ws = 4'h3;
        wr_reg(4, 32'h5, 0);
        ws = 4'hF;
        rd_reg(4, 32'h3, 0);
        $display("test trigger done");
        // Undefined select, other bank, other manager
        wr_reg(8, 32'hFFFF_FFFF, 0);
        rd_reg(8, 0, 0);
        wr_reg(32'h400, 32'h7, 3);
        rd_reg(32'h400, 0, 3);
        wr_reg(32'h1000, 32'h0, 3);
        chk(cv, 0);
        rd_reg(32'h1004, 0, 3);
        rd_reg(4, 32'h3, 0);
        $display("test decode done");
        final_report;
    end
endmodule // tb_smgr_general_regs
